// ---- core/sdps_defines.svh ----
// constants for the strap decode and protection status block
`ifndef SDPS_DEFINES_SVH
`define SDPS_DEFINES_SVH
// fixed internal clock rate in kHz
`define SDPS_CLK_KHZ 250000
// power-good delay after startup ramp, in ns, and cycle count (rounded up)
`define SDPS_PGOOD_DELAY_NS 90000
`define SDPS_PGOOD_DELAY_CYC ((`SDPS_PGOOD_DELAY_NS * 250 + 999) / 1000)
// delay between strap capture and decode latch
`define SDPS_STRAP_SETTLE_CYC 16
// high-frequency clock used for pwm division, in kHz
`define SDPS_PWM_CLK_KHZ 250000
// temperature gain/offset codes, variant one, capacitance classes 0..3
`define SDPS_V1_GAIN0 16'h64B8
`define SDPS_V1_OFFS0 16'hF20B
`define SDPS_V1_GAIN1 16'h5C18
`define SDPS_V1_OFFS1 16'h05F0
`define SDPS_V1_GAIN2 16'h5E10
`define SDPS_V1_OFFS2 16'h0690
`define SDPS_V1_GAIN3 16'h64B8
`define SDPS_V1_OFFS3 16'hF20B
// temperature gain/offset codes, variant two
`define SDPS_V2_GAIN0 16'h64B8
`define SDPS_V2_OFFS0 16'hF20B
`define SDPS_V2_GAIN1 16'h5E10
`define SDPS_V2_OFFS1 16'h05A0
`define SDPS_V2_GAIN2 16'h63E8
`define SDPS_V2_OFFS2 16'h0C80
`define SDPS_V2_GAIN3 16'h6058
`define SDPS_V2_OFFS3 16'h0910
// fixed-point q16 default input scale: 0.06822 * 65536
`define SDPS_VIN_SCALE_DEFAULT 16'h1177
`endif

// ---- core/sdps_pkg.sv ----
// types for the strap decode and protection status block
package sdps_pkg;
  // eight nominal frequencies, index 0..7 = 300,350,400,450,500,600,700,800 kHz
  typedef logic [2:0] sdps_freq_type;
  // slope groups lowest to highest
  typedef enum logic [1:0] {SLOPE_LOWEST = 2'h0, SLOPE_MID_LOW = 2'h1, SLOPE_MID_HIGH = 2'h2,
    SLOPE_HIGHEST = 2'h3} sdps_slope_type;
  // fault response selection
  typedef enum logic [1:0] {RESP_SHUTDOWN = 2'h0, RESP_RETRY = 2'h1, RESP_IGNORE = 2'h2} sdps_resp_type;
  // per-output sequencing states, gray along the usual path
  typedef enum logic [2:0] {OUT_OFF = 3'h0, OUT_RAMP = 3'h1, OUT_WAIT = 3'h3, OUT_GOOD = 3'h2,
    OUT_HALT = 3'h6} sdps_outst_type;
endpackage

// ---- core/sdps_out_channel.sv ----
// one output channel: power-good sequencing and protection responses
`timescale 1ns/1ns
`include "sdps_defines.svh"
module sdps_out_channel
  import sdps_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic regEnable, // uvlo passed and output enabled
  input wire logic rampDone, // startup ramp completed
  input wire logic belowGoodFall, // voltage under power-good falling threshold
  input wire logic stageLow, // stage temp sense pin pulled low
  input wire logic [3:0] faultHit, // telemetry oc, ceiling oc, telemetry ov, fast ov
  input wire logic ceilOvHit, // catastrophic overvoltage
  input wire sdps_pkg::sdps_resp_type respSel [5], // response per protection
  input wire logic hostClear, // host clears latched faults
  output logic outputGoodFlag, // power-good, good state gated by belowGoodFall without a register
  output logic outputGoodOe, // open-drain pulls low when not good
  output logic runOut, // regulation allowed
  output logic stageFault, // stage fault latched
  output logic [4:0] faultLatched // latched fault indications
);
  import sdps_pkg::*;
  typedef struct packed {
    sdps_outst_type st;
    logic [15:0] cnt;
    logic [4:0] flt;
    logic stage;
  } sdps_ch_type;
  sdps_ch_type s_r; // registered state
  sdps_ch_type s_nxt; // next state
  logic [4:0] hit; // all protection trips
  logic shutHit; // trip with shutdown-style response
  // gather trips and classify by configured response
  always_comb
  begin
    s_nxt = s_r;
    hit = {ceilOvHit, faultHit};
    shutHit = 1'b0;
    // host clear first, so a trip in the same cycle still latches
    if (hostClear) s_nxt.flt = 5'h00;
    for (int i = 0; i < 5; i++)
    begin
      // latch shutdown faults until host or re-enable
      if (hit[i] && respSel[i] == RESP_SHUTDOWN) s_nxt.flt[i] = 1'b1;
      if (hit[i] && respSel[i] != RESP_IGNORE) shutHit = 1'b1;
    end
    // stage fault while regulating
    if (stageLow && (s_r.st == OUT_WAIT || s_r.st == OUT_GOOD)) s_nxt.stage = 1'b1;
    // disable clears the latched faults but not the stage fault, the output is off anyway
    if (!regEnable) s_nxt.flt = 5'h00;
    case (s_r.st)
      OUT_OFF:
      begin
        if (regEnable && s_nxt.flt == 5'h00) s_nxt.st = OUT_RAMP;
      end
      OUT_RAMP:
      begin
        s_nxt.cnt = 16'h0000;
        if (rampDone)
        begin
          s_nxt.st = OUT_WAIT;
          s_nxt.stage = 1'b0;
        end
      end
      OUT_WAIT:
      begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
        if (s_r.cnt == 16'(`SDPS_PGOOD_DELAY_CYC - 1)) s_nxt.st = OUT_GOOD;
      end
      OUT_GOOD: ;
      // halt is left by the response chain below
      OUT_HALT: ;
      default: s_nxt.st = OUT_OFF;
    endcase
    // shutdown on disable, fault or stage fault
    if (!regEnable) s_nxt.st = OUT_OFF;
    else if (shutHit || (stageLow && s_r.st != OUT_OFF && s_r.st != OUT_RAMP)) s_nxt.st = OUT_HALT;
    else if (s_r.st == OUT_HALT && s_nxt.flt == 5'h00) s_nxt.st = OUT_OFF;
  end
  // register the channel state
  always_ff @(posedge clk)
  begin
    if (srst) s_r <= '0;
    else s_r <= s_nxt;
  end
  // good only once delay passed and voltage is above falling threshold
  assign outputGoodFlag = (s_r.st == OUT_GOOD) && !belowGoodFall;
  assign outputGoodOe = !outputGoodFlag;
  assign runOut = s_r.st != OUT_OFF && s_r.st != OUT_HALT;
  assign stageFault = s_r.stage;
  assign faultLatched = s_r.flt;
endmodule // sdps_out_channel

// ---- core/sdps_strap_status.sv ----
// strap decode, command override and protection status for two outputs
`timescale 1ns/1ns
`include "sdps_defines.svh"
// Overview of operation
// - single-output strap: 32 bins, four slope groups
// - eight nominal switching frequencies only
// - dual-output straps give upper four frequencies
// - single-output strap reaches all eight frequencies
// - frequency command overrides strap in both modes
// - pwm frequency by integer clock division
// - one strap gain/offset loads both outputs
// - capacitance class maps to gain/offset codes
// - stage class from reference-pin capacitance
// - host gain/offset writes override strap values
// - regulation waits for input undervoltage comparator
// - input sense digitized and scaled for telemetry
// - power-good asserts 90us after ramp end
// - power-good drops on low, fault, disable
// - one open-drain active-high power-good per output
// - stage sense low while regulating flags fault
// - stage fault released after successful restart
// - telemetry and hardware ceiling overcurrent detections
// - shutdown, retry or ignore per protection
// - telemetry overvoltage with its own response
// - fast overvoltage comparator with own response
// - catastrophic overvoltage with ceiling response
module sdps_strap_status
  import sdps_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic dualOutput, // dual-output configuration
  input wire logic stageVariant, // 0 variant one table, 1 variant two
  input wire logic [4:0] freqSlopeStrapPin, // decoded resistor bin of freq/slope strap
  input wire logic coarseStrapPin, // coarse strap half, high = 1
  input wire logic [1:0] stageSelectCapacitance, // capacitance class 0,100,330,1000 pF
  input wire logic freqCmdValid, // frequency command write strobe
  input wire sdps_pkg::sdps_freq_type freqCmd, // frequency command index
  input wire logic [1:0] tempCmdValid, // per-output gain/offset write strobe
  input wire logic [15:0] tempGainCmd, // written gain
  input wire logic [15:0] tempOffsCmd, // written offset
  input wire logic [2:0] phaseNum0, // phases on output 0 (1..6)
  input wire logic [2:0] phaseNum1, // phases on output 1 (1..6)
  input wire logic inputUndervoltOk, // uvlo comparator above rising threshold
  input wire logic [11:0] inputUndervoltSense, // digitized input sense
  input wire logic [15:0] vinScaleCmd, // scale factor q16
  input wire logic vinScaleValid, // scale write strobe
  input wire logic [1:0] outEnable, // per-output enable
  input wire logic [1:0] rampDone, // startup ramp complete
  input wire logic [1:0] belowGoodFall, // under falling threshold
  input wire logic [1:0] stageTempSensePin, // temp sense pin level per output
  input wire logic [1:0] telemOcHit, // telemetry current above limit
  input wire logic [1:0] ceilOcHit, // current design resistor at 500mV ceiling
  input wire logic [1:0] telemOvHit, // telemetry voltage above limit
  input wire logic [1:0] fastOvHit, // 240mV above target comparator
  input wire logic [1:0] ceilOvHit, // 2.7V absolute comparator
  input wire sdps_pkg::sdps_resp_type ocResp, // telemetry overcurrent response
  input wire sdps_pkg::sdps_resp_type currentCeilingResponse, // hardware ceiling response
  input wire sdps_pkg::sdps_resp_type ovResp, // telemetry overvoltage response
  input wire sdps_pkg::sdps_resp_type fastOvervoltResponse, // fast overvoltage response
  input wire sdps_pkg::sdps_resp_type voltageCeilingResponse, // catastrophic response
  input wire logic [1:0] hostClear, // host clear per output
  output sdps_pkg::sdps_freq_type freqSel, // active frequency index
  output sdps_pkg::sdps_slope_type rampSlopeSetting, // slope group
  output logic [11:0] pwmDivider0, // clock divider output 0
  output logic [11:0] pwmDivider1, // clock divider output 1
  output logic [15:0] tempGain0, // active gain output 0
  output logic [15:0] tempOffs0, // active offset output 0
  output logic [15:0] tempGain1, // active gain output 1
  output logic [15:0] tempOffs1, // active offset output 1
  output logic [27:0] readVin, // scaled input telemetry
  output logic strapsLatched, // strap decode valid
  output logic [1:0] regRun, // regulation allowed per output
  output logic [1:0] outputGoodFlag, // power-good per output
  output logic [1:0] outputGoodOe, // open-drain enable, pulls low
  output logic stageFaultN, // shared active-low stage fault level
  output logic stageFaultOe, // open-drain enable for stage fault
  output logic [4:0] faultLatched0, // latched faults output 0
  output logic [4:0] faultLatched1 // latched faults output 1
);
  import sdps_pkg::*;
  typedef struct packed {
    logic [4:0] settle;
    logic done;
    sdps_freq_type freq;
    sdps_slope_type slope;
    logic [15:0] gain0;
    logic [15:0] offs0;
    logic [15:0] gain1;
    logic [15:0] offs1;
    logic [15:0] scale;
    logic [27:0] vin;
    logic [11:0] div0;
    logic [11:0] div1;
  } sdps_top_type;
  sdps_top_type s_r; // registered state
  sdps_top_type s_nxt; // next state
  logic [15:0] strapGain; // strap-derived gain
  logic [15:0] strapOffs; // strap-derived offset
  sdps_freq_type strapFreq; // strap-derived frequency
  logic [1:0] good; // per-channel good
  logic [1:0] stageF; // per-channel stage fault
  logic [4:0] flt [2]; // per-channel latched faults
  sdps_resp_type resp [5]; // response table shared by channels
  // nominal frequency in kHz by index
  function automatic logic [9:0] freqKhz(input sdps_freq_type f);
    case (f)
      3'h0: freqKhz = 10'd300;
      3'h1: freqKhz = 10'd350;
      3'h2: freqKhz = 10'd400;
      3'h3: freqKhz = 10'd450;
      3'h4: freqKhz = 10'd500;
      3'h5: freqKhz = 10'd600;
      3'h6: freqKhz = 10'd700;
      default: freqKhz = 10'd800;
    endcase
  endfunction
  // integer divider for a phase count: clock / (f * phases)
  function automatic logic [11:0] divFor(input sdps_freq_type f, input logic [2:0] n);
    logic [31:0] q;
    q = `SDPS_PWM_CLK_KHZ / (32'(freqKhz(f)) * 32'((n == 3'h0) ? 3'h1 : n));
    divFor = q[11:0];
  endfunction
  // strap decode of frequency and stage class
  always_comb
  begin
    // dual: coarse high/low on bin msb and coarse strap pick upper four
    if (dualOutput) strapFreq = {1'b1, freqSlopeStrapPin[4], coarseStrapPin};
    else strapFreq = freqSlopeStrapPin[2:0];
    // capacitance class to codes, both tables
    case ({stageVariant, stageSelectCapacitance})
      3'h0: {strapGain, strapOffs} = {`SDPS_V1_GAIN0, `SDPS_V1_OFFS0};
      3'h1: {strapGain, strapOffs} = {`SDPS_V1_GAIN1, `SDPS_V1_OFFS1};
      3'h2: {strapGain, strapOffs} = {`SDPS_V1_GAIN2, `SDPS_V1_OFFS2};
      3'h3: {strapGain, strapOffs} = {`SDPS_V1_GAIN3, `SDPS_V1_OFFS3};
      3'h4: {strapGain, strapOffs} = {`SDPS_V2_GAIN0, `SDPS_V2_OFFS0};
      3'h5: {strapGain, strapOffs} = {`SDPS_V2_GAIN1, `SDPS_V2_OFFS1};
      3'h6: {strapGain, strapOffs} = {`SDPS_V2_GAIN2, `SDPS_V2_OFFS2};
      default: {strapGain, strapOffs} = {`SDPS_V2_GAIN3, `SDPS_V2_OFFS3};
    endcase
  end
  // strap latch, overrides and telemetry scaling
  always_comb
  begin
    s_nxt = s_r;
    // latch straps once after settling, hold until reset
    if (!s_r.done)
    begin
      s_nxt.settle = s_r.settle + 5'h01;
      if (s_r.settle == 5'(`SDPS_STRAP_SETTLE_CYC))
      begin
        s_nxt.done = 1'b1;
        s_nxt.freq = strapFreq;
        s_nxt.slope = sdps_slope_type'(dualOutput ? 2'h0 : freqSlopeStrapPin[4:3]);
        s_nxt.gain0 = strapGain;
        s_nxt.offs0 = strapOffs;
        s_nxt.gain1 = strapGain;
        s_nxt.offs1 = strapOffs;
      end
    end
    else
    begin
      // host frequency command reaches any of eight
      if (freqCmdValid) s_nxt.freq = freqCmd;
      // independent per-output temperature scaling
      if (tempCmdValid[0])
      begin
        s_nxt.gain0 = tempGainCmd;
        s_nxt.offs0 = tempOffsCmd;
      end
      if (tempCmdValid[1])
      begin
        s_nxt.gain1 = tempGainCmd;
        s_nxt.offs1 = tempOffsCmd;
      end
    end
    if (vinScaleValid) s_nxt.scale = vinScaleCmd;
    s_nxt.vin = 28'(inputUndervoltSense) * 28'(s_r.scale);
    s_nxt.div0 = divFor(s_r.freq, phaseNum0);
    s_nxt.div1 = divFor(s_r.freq, phaseNum1);
  end
  // register top state
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_r <= '0;
      s_r.scale <= `SDPS_VIN_SCALE_DEFAULT;
    end
    else s_r <= s_nxt;
  end
  assign resp[0] = ocResp;
  assign resp[1] = currentCeilingResponse;
  assign resp[2] = ovResp;
  assign resp[3] = fastOvervoltResponse;
  assign resp[4] = voltageCeilingResponse;
  // one channel per output
  for (genvar c = 0; c < 2; c++)
  begin : gCh
    sdps_out_channel uCh (
      .clk(clk),
      .srst(srst),
      .regEnable(outEnable[c] && inputUndervoltOk && s_r.done),
      .rampDone(rampDone[c]),
      .belowGoodFall(belowGoodFall[c]),
      .stageLow(!stageTempSensePin[c]),
      .faultHit({fastOvHit[c], telemOvHit[c], ceilOcHit[c], telemOcHit[c]}),
      .ceilOvHit(ceilOvHit[c]),
      .respSel(resp),
      .hostClear(hostClear[c]),
      .outputGoodFlag(good[c]),
      .outputGoodOe(outputGoodOe[c]),
      .runOut(regRun[c]),
      .stageFault(stageF[c]),
      .faultLatched(flt[c])
    );
  end
  assign outputGoodFlag = good;
  assign stageFaultN = !(|stageF);
  assign stageFaultOe = |stageF;
  assign faultLatched0 = flt[0];
  assign faultLatched1 = flt[1];
  assign freqSel = s_r.freq;
  assign rampSlopeSetting = s_r.slope;
  assign pwmDivider0 = s_r.div0;
  assign pwmDivider1 = s_r.div1;
  assign tempGain0 = s_r.gain0;
  assign tempOffs0 = s_r.offs0;
  assign tempGain1 = s_r.gain1;
  assign tempOffs1 = s_r.offs1;
  assign readVin = s_r.vin;
  assign strapsLatched = s_r.done;
endmodule // sdps_strap_status

// ---- sim/sdps_far_side_model.sv ----
// far-side strap parts and stage sense pins seen by the block
`timescale 1ns/1ns
module sdps_far_side_model (
  input wire logic [4:0] binSel, // resistor bin fitted on the strap
  input wire logic coarseSel, // coarse strap half fitted
  input wire logic [1:0] capSel, // capacitor class beside the reference resistor
  input wire logic [1:0] stageLowReq, // a power stage pulls its sense pin low
  output logic [4:0] freqSlopeStrapPin, // settled strap bin
  output logic coarseStrapPin, // settled coarse half
  output logic [1:0] stageSelectCapacitance, // settled capacitance class
  output logic [1:0] stageTempSensePin // sense level
);
  // passive straps: the decode follows the fitted parts
  assign freqSlopeStrapPin = binSel;
  assign coarseStrapPin = coarseSel;
  assign stageSelectCapacitance = capSel;
  // pull-up wins unless a faulted stage pulls low
  assign stageTempSensePin = ~stageLowReq;
endmodule // sdps_far_side_model

// ---- sim/sdps_strap_status_assertions.sv ----
// port-level checks of the strap decode and protection status block
`timescale 1ns/1ns
module sdps_strap_status_assertions
  import sdps_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic freqCmdValid,
  input wire sdps_pkg::sdps_freq_type freqCmd,
  input wire logic [1:0] tempCmdValid,
  input wire logic [15:0] tempGainCmd,
  input wire logic inputUndervoltOk,
  input wire logic [1:0] outEnable,
  input wire logic [1:0] belowGoodFall,
  input wire logic [1:0] telemOcHit,
  input wire sdps_pkg::sdps_resp_type ocResp,
  input wire logic [1:0] hostClear,
  input wire sdps_pkg::sdps_freq_type freqSel,
  input wire sdps_pkg::sdps_slope_type rampSlopeSetting,
  input wire logic [15:0] tempGain0,
  input wire logic strapsLatched,
  input wire logic [1:0] regRun,
  input wire logic [1:0] outputGoodFlag,
  input wire logic [1:0] outputGoodOe,
  input wire logic stageFaultN,
  input wire logic stageFaultOe,
  input wire logic [4:0] faultLatched0
);
  // one clock domain, reset disables all checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_cmd_sets_freq: assert property (freqCmdValid && strapsLatched |=> freqSel == $past(freqCmd))
    else $error("frequency command not applied");
  a_gain_write_used: assert property (tempCmdValid[0] && strapsLatched |=> tempGain0 == $past(tempGainCmd))
    else $error("written gain not used");
  a_straps_held: assert property (strapsLatched |=> strapsLatched && $stable(rampSlopeSetting))
    else $error("strap decode changed after latch");
  a_uvlo_gates_run: assert property ($rose(regRun[0]) |-> $past(inputUndervoltOk))
    else $error("regulation started without uvlo");
  a_good_drops_low: assert property (belowGoodFall[0] |-> !outputGoodFlag[0])
    else $error("power-good high while output low");
  a_good_needs_run: assert property (outputGoodFlag[0] |-> regRun[0])
    else $error("power-good high while not regulating");
  a_good_pin_level: assert property (outputGoodOe == ~outputGoodFlag)
    else $error("power-good drain does not match flag");
  a_stage_pin_level: assert property (stageFaultOe != stageFaultN)
    else $error("stage fault drain does not match level");
  a_shutdown_latches: assert property (telemOcHit[0] && ocResp == RESP_SHUTDOWN && regRun[0] && outEnable[0]
    && inputUndervoltOk && !hostClear[0] |=> !regRun[0] && faultLatched0[0] && !outputGoodFlag[0])
    else $error("shutdown response not taken");
  a_latch_holds: assert property (faultLatched0[0] && !regRun[0] && ocResp == RESP_SHUTDOWN && outEnable[0]
    && inputUndervoltOk && !hostClear[0] |=> faultLatched0[0])
    else $error("latched fault lost without clear");
  a_disable_clears: assert property (!outEnable[0] |=> faultLatched0 == 5'h00)
    else $error("disable did not clear faults");
endmodule // sdps_strap_status_assertions

bind sdps_strap_status sdps_strap_status_assertions u_chk (.clk, .srst, .freqCmdValid, .freqCmd, .tempCmdValid,
  .tempGainCmd, .inputUndervoltOk, .outEnable, .belowGoodFall, .telemOcHit, .ocResp, .hostClear, .freqSel,
  .rampSlopeSetting, .tempGain0, .strapsLatched, .regRun, .outputGoodFlag, .outputGoodOe, .stageFaultN,
  .stageFaultOe, .faultLatched0);

// ---- sim/tb_sdps_strap_status.sv ----
// self-checking bench for the strap decode and protection status block
`timescale 1ns/1ns
module tb_sdps_strap_status;
  import sdps_pkg::*;
  logic clk = 1'b0, srst = 1'b1, dualOutput = 1'b0, stageVariant = 1'b0, coarseSel = 1'b0;
  logic freqCmdValid = 1'b0, inputUndervoltOk = 1'b0, vinScaleValid = 1'b0;
  logic [4:0] binSel = 5'h00, hit0 = 5'h00, hit1 = 5'h00, lat;
  logic [1:0] capSel = 2'h0, stageLowReq = 2'h0, tempCmdValid = 2'h0, outEnable = 2'h0;
  logic [1:0] rampDone = 2'h0, belowGoodFall = 2'h0, hostClear = 2'h0;
  sdps_freq_type freqCmd = 3'h0;
  sdps_resp_type rs [5] = '{default: RESP_SHUTDOWN}; // response per protection
  logic [15:0] tempGainCmd = 16'h0000, tempOffsCmd = 16'h0000, vinScaleCmd = 16'h0000, g;
  logic [11:0] inputUndervoltSense = 12'h000;
  logic [2:0] phaseNum0 = 3'h1, phaseNum1 = 3'h1, ef;
  wire logic [4:0] freqSlopeStrapPin;
  wire logic coarseStrapPin;
  wire logic [1:0] stageSelectCapacitance, stageTempSensePin;
  sdps_freq_type freqSel;
  sdps_slope_type rampSlopeSetting;
  logic [11:0] pwmDivider0, pwmDivider1;
  logic [15:0] tempGain0, tempOffs0, tempGain1, tempOffs1;
  logic [27:0] readVin;
  logic strapsLatched, stageFaultN, stageFaultOe;
  logic [1:0] regRun, outputGoodFlag, outputGoodOe;
  logic [4:0] faultLatched0, faultLatched1;
  int failures = 0, comparisons = 0, cycles = 0, i, j, k, n, o, p, r;
  int seed = 32'h56b148c2;
  int khz [8] = '{300, 350, 400, 450, 500, 600, 700, 800}; // nominal frequencies
  // gain/offset per {variant, capacitance class}
  logic [15:0] gTab [8] = '{16'h64B8, 16'h5C18, 16'h5E10, 16'h64B8, 16'h64B8, 16'h5E10, 16'h63E8, 16'h6058};
  logic [15:0] oTab [8] = '{16'hF20B, 16'h05F0, 16'h0690, 16'hF20B, 16'hF20B, 16'h05A0, 16'h0C80, 16'h0910};
  sdps_far_side_model far (.binSel, .coarseSel, .capSel, .stageLowReq, .freqSlopeStrapPin, .coarseStrapPin,
    .stageSelectCapacitance, .stageTempSensePin);
  sdps_strap_status dut (.clk, .srst, .dualOutput, .stageVariant, .freqSlopeStrapPin, .coarseStrapPin,
    .stageSelectCapacitance, .freqCmdValid, .freqCmd, .tempCmdValid, .tempGainCmd, .tempOffsCmd,
    .phaseNum0, .phaseNum1, .inputUndervoltOk, .inputUndervoltSense, .vinScaleCmd,
    .vinScaleValid, .outEnable, .rampDone, .belowGoodFall, .stageTempSensePin, .telemOcHit({hit1[0], hit0[0]}),
    .ceilOcHit({hit1[1], hit0[1]}), .telemOvHit({hit1[2], hit0[2]}), .fastOvHit({hit1[3], hit0[3]}),
    .ceilOvHit({hit1[4], hit0[4]}), .ocResp(rs[0]), .currentCeilingResponse(rs[1]), .ovResp(rs[2]),
    .fastOvervoltResponse(rs[3]), .voltageCeilingResponse(rs[4]), .hostClear, .freqSel, .rampSlopeSetting,
    .pwmDivider0, .pwmDivider1, .tempGain0, .tempOffs0, .tempGain1, .tempOffs1, .readVin, .strapsLatched, .regRun,
    .outputGoodFlag, .outputGoodOe, .stageFaultN, .stageFaultOe, .faultLatched0, .faultLatched1);
  // 250 MHz clock
  initial
  begin
    forever #2 clk = ~clk;
  end
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      conclude();
    end
  end
  // verdict and end of run
  task automatic conclude;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // wait edges, then land just after the last one
  task automatic step(input int cnt);
    repeat (cnt) @(posedge clk);
    #1;
  endtask
  // compare one result against the model
  task automatic chk(input string what, input logic [27:0] exp, input logic [27:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // reset, offer a command too early, wait for the strap latch
  task automatic restart;
    srst = 1'b1;
    step(5);
    chk("good oe", 28'h3, 28'(outputGoodOe));
    chk("stage fault", 28'h1, 28'(stageFaultN));
    srst = 1'b0;
    freqCmdValid = 1'b1;
    freqCmd = ~ef;
    step(1);
    freqCmdValid = 1'b0;
    for (n = 0; n < 40 && strapsLatched !== 1'b1; n++) step(1);
    step(1);
  endtask
  // main sequence
  initial
  begin
    for (i = 0; i < 8; i++)
    begin
      binSel = (i == 0) ? 5'h00 : (i == 7) ? 5'h1F : 5'($random(seed));
      coarseSel = 1'($random(seed));
      capSel = 2'(i);
      stageVariant = i[2];
      dualOutput = i[0] ^ i[1];
      phaseNum0 = 3'(1 + {$random(seed)} % 6);
      phaseNum1 = 3'h7 - phaseNum0;
      ef = dualOutput ? {1'b1, binSel[4], coarseSel} : binSel[2:0];
      restart();
      chk("freq strap", 28'(ef), 28'(freqSel));
      chk("slope", 28'(dualOutput ? 2'h0 : binSel[4:3]), 28'(rampSlopeSetting));
      chk("divider0", 28'(250000 / (khz[ef] * phaseNum0)), 28'(pwmDivider0));
      chk("gain0", 28'(gTab[i]), 28'(tempGain0));
      chk("offs1", 28'(oTab[i]), 28'(tempOffs1));
      binSel = ~binSel;
      capSel = ~capSel;
      coarseSel = ~coarseSel;
      step(3);
      chk("freq held", 28'(ef), 28'(freqSel));
      chk("gain held", 28'(gTab[i]), 28'(tempGain1));
      freqCmdValid = 1'b1;
      for (j = 0; j < 9; j++)
      begin
        freqCmd = 3'(j);
        step(1);
        if (j < 8) chk("freq cmd", 28'(j), 28'(freqSel));
        if (j > 0) chk("divider1", 28'(250000 / (khz[j - 1] * phaseNum1)), 28'(pwmDivider1));
      end
      freqCmdValid = 1'b0;
      g = 16'($random(seed));
      tempGainCmd = g;
      tempOffsCmd = ~g;
      tempCmdValid = 2'b01;
      step(1);
      tempGainCmd = ~g;
      tempOffsCmd = g;
      tempCmdValid = 2'b10;
      step(1);
      tempCmdValid = 2'b00;
      chk("gain0 cmd", 28'(g), 28'(tempGain0));
      chk("offs0 cmd", 28'(g ^ 16'hFFFF), 28'(tempOffs0));
      chk("gain1 cmd", 28'(g ^ 16'hFFFF), 28'(tempGain1));
      chk("offs1 cmd", 28'(g), 28'(tempOffs1));
      inputUndervoltSense = 12'($random(seed));
      step(2);
      chk("vin default", 28'(inputUndervoltSense) * 28'h1177, readVin);
      vinScaleCmd = 16'($random(seed));
      vinScaleValid = 1'b1;
      step(1);
      vinScaleValid = 1'b0;
      step(1);
      chk("vin scaled", 28'(inputUndervoltSense) * 28'(vinScaleCmd), readVin);
    end
    outEnable = 2'b11;
    step(4);
    chk("run without uvlo", 28'h0, 28'(regRun));
    inputUndervoltOk = 1'b1;
    step(2);
    chk("run", 28'h3, 28'(regRun));
    rampDone = 2'b11;
    for (n = 0; n < 23000 && outputGoodFlag[0] !== 1'b1; n++) step(1);
    chk("good delay", 28'h1, 28'(n >= 22499 && n <= 22501));
    step(1);
    chk("good both", 28'h3, 28'(outputGoodFlag));
    belowGoodFall = 2'b01;
    step(1);
    chk("good low", 28'h2, 28'(outputGoodFlag));
    belowGoodFall = 2'b00;
    stageLowReq = 2'b10;
    step(2);
    chk("stage fault set", 28'h0, 28'(stageFaultN));
    chk("stage fault oe", 28'h1, 28'(stageFaultOe));
    stageLowReq = 2'b00;
    outEnable = 2'b01;
    rampDone = 2'b01;
    step(2);
    chk("stage fault held", 28'h0, 28'(stageFaultN));
    chk("good disabled", 28'h1, 28'(outputGoodFlag));
    outEnable = 2'b11;
    step(3);
    rampDone = 2'b11;
    step(3);
    chk("stage fault free", 28'h1, 28'(stageFaultN));
    for (o = 0; o < 2; o++)
      for (p = 0; p < 5; p++)
        for (r = 0; r < 3; r++)
        begin
          for (k = 0; k < 5; k++) rs[k] = sdps_resp_type'((k == p) ? r : (r + 1) % 3);
          {hit1, hit0} = 10'(1 << (p + 5 * o));
          step(1);
          chk("run on trip", 28'(r == 2), 28'(regRun[o]));
          {hit1, hit0} = 10'h000;
          step(3);
          lat = o ? faultLatched1 : faultLatched0;
          chk("latched", 28'(r == 0), 28'(lat[p]));
          chk("run after trip", 28'(r != 0), 28'(regRun[o]));
          hostClear[o] = 1'b1;
          step(1);
          hostClear = 2'b00;
          step(3);
          lat = o ? faultLatched1 : faultLatched0;
          chk("cleared", 28'h0, 28'(lat));
          chk("restarted", 28'h1, 28'(regRun[o]));
        end
    conclude();
  end
endmodule // tb_sdps_strap_status
